/* File: rtl/mdio_pkg.sv */
package mdio_pkg;

  // bus geometry
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] REG_IN_FUNC   = 8'h00;
  localparam logic [7:0] REG_OUT_FUNC  = 8'h04;
  localparam logic [7:0] REG_OL_TIME   = 8'h08;
  localparam logic [7:0] REG_WARN_LVL  = 8'h0C;
  localparam logic [7:0] REG_BAND      = 8'h10;
  localparam logic [7:0] REG_CTRL      = 8'h14;
  localparam logic [7:0] REG_RATIO_RED = 8'h18;
  localparam logic [7:0] REG_RATIO_INC = 8'h1C;
  localparam logic [7:0] REG_STATUS    = 8'h20;
  localparam logic [7:0] REG_OL_COUNT  = 8'h24;

  // control register bit positions
  localparam int CTRL_INIT_BIT  = 0;
  localparam int CTRL_HOLD_BIT  = 1;
  localparam int CTRL_CLEAR_BIT = 2;

  // input terminal function codes
  localparam logic [2:0] IN_NONE  = 3'h0;
  localparam logic [2:0] IN_FWD   = 3'h1;
  localparam logic [2:0] IN_BWD   = 3'h2;
  localparam logic [2:0] IN_SEL_L = 3'h3;
  localparam logic [2:0] IN_SEL_H = 3'h4;
  localparam logic [2:0] IN_CLEAR = 3'h5;
  localparam logic [2:0] IN_EXTF  = 3'h6;
  localparam logic [2:0] IN_HFREE = 3'h7;

  // output terminal function codes
  localparam logic [2:0] OUT_NONE  = 3'h0;
  localparam logic [2:0] OUT_MAIN  = 3'h1;
  localparam logic [2:0] OUT_TACH  = 3'h2;
  localparam logic [2:0] OUT_OVLD  = 3'h3;
  localparam logic [2:0] OUT_MOVE  = 3'h4;
  localparam logic [2:0] OUT_SPEED = 3'h5;
  localparam logic [2:0] OUT_WARN  = 3'h6;

  // factory settings and ranges
  localparam logic [8:0]  IN_FUNC_DEF   = {IN_SEL_L, IN_BWD, IN_FWD};
  localparam logic [5:0]  OUT_FUNC_DEF  = {OUT_MAIN, OUT_TACH};
  localparam logic [9:0]  OL_TIME_DEF   = 10'h12C;
  localparam logic [9:0]  OL_TIME_MIN   = 10'h001;
  localparam logic [9:0]  OL_TIME_MAX   = 10'h258;
  localparam logic [7:0]  WARN_LVL_DEF  = 8'h78;
  localparam logic [7:0]  WARN_LVL_MIN  = 8'h32;
  localparam logic [7:0]  WARN_LVL_MAX  = 8'h78;
  localparam logic [8:0]  BAND_DEF      = 9'h0C8;
  localparam logic [8:0]  BAND_MAX      = 9'h190;
  localparam logic [15:0] RATIO_UNITY   = 16'h0064;
  localparam logic [15:0] RATIO_INC_MAX = 16'h00C8;
  localparam logic        HOLD_DEF      = 1'b0;

  // timing
  localparam int CLK_HZ            = 100_000_000;
  localparam int OL_TICK_MS        = 100;
  localparam int OL_TICK_CYCLES    = CLK_HZ / 1000 * OL_TICK_MS;
  localparam int OL_FAST_S         = 5;
  localparam logic [9:0] OL_FAST_TICKS = 10'(OL_FAST_S * 1000 / OL_TICK_MS);
  localparam int TACH_PULSE_US     = 200;
  localparam int TACH_PULSE_CYCLES = CLK_HZ / 1_000_000 * TACH_PULSE_US;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WS_COLLECT = 2'b01, WS_RESP = 2'b10} mdio_wstate_e;
  typedef enum logic [1:0] {RS_IDLE = 2'b01, RS_DATA = 2'b10} mdio_rstate_e;

  function automatic logic [31:0] mdio_clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    mdio_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : mdio_clamp

  function automatic logic [31:0] mdio_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      mdio_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction : mdio_merge

  function automatic logic [15:0] mdio_absdiff(input logic [15:0] a, input logic [15:0] b);
    mdio_absdiff = (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction : mdio_absdiff

endpackage : mdio_pkg

/* File: rtl/mdio_top.sv */
module mdio_top
  import mdio_pkg::*;
#(
  parameter int TICK_CYCLES  = mdio_pkg::OL_TICK_CYCLES,
  parameter int PULSE_CYCLES = mdio_pkg::TACH_PULSE_CYCLES
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [mdio_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [mdio_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      input_terminal_a,
  input  wire logic                      input_terminal_b,
  input  wire logic                      input_terminal_c,
  output logic                           output_terminal_a,
  output logic                           output_terminal_b,
  input  wire logic [15:0]               motor_speed_in,
  input  wire logic [15:0]               command_speed_in,
  input  wire logic [7:0]                load_factor_in,
  input  wire logic                      overload_cont_in,
  input  wire logic                      overload_limit_in,
  input  wire logic                      shaft_locked_in,
  input  wire logic                      rotation_tick_in,
  input  wire logic                      motor_running_in,
  input  wire logic                      drive_warning_in,
  output logic                           run_forward,
  output logic                           run_backward,
  output logic                           stop_instant,
  output logic [1:0]                     data_number,
  output logic                           alarm_active,
  output logic                           hold_release,
  output logic                           position_keep,
  output logic [15:0]                    display_ratio,
  output logic                           ratio_from_increase
);

  typedef struct packed {
    logic [2:0]        sync1;
    logic [2:0]        sync2;
    logic [8:0]        in_func;
    logic [5:0]        out_func;
    logic [9:0]        ol_time;
    logic [7:0]        warn_lvl;
    logic [8:0]        band;
    logic              hold_en;
    logic [15:0]       ratio_red;
    logic [15:0]       ratio_inc;
    logic [31:0]       tick_cnt;
    logic [9:0]        ol_ticks;
    logic              ol_alarm;
    logic              ext_alarm;
    logic              clr_prev;
    logic [31:0]       tach_cnt;
    mdio_wstate_e      wstate;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    mdio_rstate_e      rstate;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              out_a;
    logic              out_b;
    logic              run_fwd;
    logic              run_bwd;
    logic              stop;
    logic [1:0]        data_num;
    logic              alarm;
    logic              hold_rel;
    logic              pos_keep;
    logic              warn;
    logic              ol_warn;
    logic              speed_ok;
    logic              moving;
    logic [15:0]       disp_ratio;
    logic              ratio_inc_sel;
  } mdio_state_s;

  function automatic mdio_state_s mdio_defaults(input mdio_state_s s);
    mdio_defaults           = s;
    mdio_defaults.in_func   = IN_FUNC_DEF;
    mdio_defaults.out_func  = OUT_FUNC_DEF;
    mdio_defaults.ol_time   = OL_TIME_DEF;
    mdio_defaults.warn_lvl  = WARN_LVL_DEF;
    mdio_defaults.band      = BAND_DEF;
    mdio_defaults.hold_en   = HOLD_DEF;
    mdio_defaults.ratio_red = RATIO_UNITY;
    mdio_defaults.ratio_inc = RATIO_UNITY;
  endfunction : mdio_defaults

  // a function is active when any terminal mapped to it is on
  function automatic logic term_hit(input logic [8:0] funcs, input logic [2:0] lvl, input logic [2:0] code);
    term_hit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      term_hit = term_hit | ((funcs[i*3 +: 3] == code) & lvl[i]);
    end
  endfunction : term_hit

  function automatic logic out_pick(input logic [2:0] code, input logic [6:0] st);
    out_pick = (code == OUT_NONE || code > OUT_WARN) ? 1'b0 : st[code];
  endfunction : out_pick

  mdio_state_s r_reg;
  mdio_state_s r_next;

  function automatic logic [31:0] reg_read(input mdio_state_s s, input logic [7:0] addr);
    case ({addr[7:2], 2'b00})
      REG_IN_FUNC:   reg_read = {23'h0, s.in_func};
      REG_OUT_FUNC:  reg_read = {26'h0, s.out_func};
      REG_OL_TIME:   reg_read = {22'h0, s.ol_time};
      REG_WARN_LVL:  reg_read = {24'h0, s.warn_lvl};
      REG_BAND:      reg_read = {23'h0, s.band};
      REG_CTRL:      reg_read = {29'h0, 1'b0, s.hold_en, 1'b0};
      REG_RATIO_RED: reg_read = {16'h0, s.ratio_red};
      REG_RATIO_INC: reg_read = {16'h0, s.ratio_inc};
      REG_STATUS:    reg_read = {15'h0, s.stop, 1'b0, s.sync2, 2'h0, s.data_num,
                                 1'b0, s.speed_ok, s.moving, s.ol_warn, s.warn,
                                 s.ext_alarm, s.ol_alarm, s.alarm};
      REG_OL_COUNT:  reg_read = {22'h0, s.ol_ticks};
      default:       reg_read = 32'h0;
    endcase
  endfunction : reg_read

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = ({addr[7:2], 2'b00} <= REG_OL_COUNT);
  endfunction : reg_mapped

  always_comb begin
    logic [31:0] wv;
    logic [2:0]  lvl;
    logic        forward_run_in;
    logic        bwd;
    logic        clr_in;
    logic        soft_clear;
    logic        do_init;
    logic        ext_bad;
    logic        ol_any;
    logic        ol_hard;
    logic        tick;
    logic [9:0]  limit;
    logic        hfree;
    logic        tach;
    logic [6:0]  st;
    wv         = 32'h0;
    {lvl, limit, st, forward_run_in, bwd, clr_in, ext_bad, ol_any, ol_hard, tick, hfree, tach} = 29'h0;
    soft_clear = 1'b0;
    do_init    = 1'b0;
    r_next     = r_reg;

    // pins pass two flops before any logic reads them
    r_next.sync1 = {input_terminal_c, input_terminal_b, input_terminal_a};
    r_next.sync2 = r_reg.sync1;
    lvl          = r_reg.sync2;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    case (r_reg.wstate)
      WS_COLLECT: begin
        if (r_reg.aw_got && r_reg.w_got) begin
          wv            = mdio_merge(reg_read(r_reg, r_reg.awaddr), r_reg.wdata, r_reg.wstrb);
          r_next.aw_got = 1'b0;
          r_next.w_got  = 1'b0;
          r_next.bvalid = 1'b1;
          r_next.bresp  = reg_mapped(r_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
          r_next.wstate = WS_RESP;
          case ({r_reg.awaddr[7:2], 2'b00})
            REG_IN_FUNC:   r_next.in_func   = wv[8:0];
            REG_OUT_FUNC:  r_next.out_func  = wv[5:0];
            // detection time in tenths, 0.1 to 60.0 s
            REG_OL_TIME:   r_next.ol_time   = 10'(mdio_clamp(wv, 32'(OL_TIME_MIN), 32'(OL_TIME_MAX)));
            // warning level 50 to 120 percent
            REG_WARN_LVL:  r_next.warn_lvl  = 8'(mdio_clamp(wv, 32'(WARN_LVL_MIN), 32'(WARN_LVL_MAX)));
            REG_BAND:      r_next.band      = 9'(mdio_clamp(wv, 32'h0, 32'(BAND_MAX)));
            REG_CTRL: begin
              r_next.hold_en = wv[CTRL_HOLD_BIT];
              do_init        = wv[CTRL_INIT_BIT];
              soft_clear     = wv[CTRL_CLEAR_BIT];
            end
            REG_RATIO_RED: r_next.ratio_red = 16'(mdio_clamp(wv, 32'(RATIO_UNITY), 32'h0000FFFF));
            REG_RATIO_INC: r_next.ratio_inc = 16'(mdio_clamp(wv, 32'(RATIO_UNITY), 32'(RATIO_INC_MAX)));
            default: ;
          endcase
        end
      end
      WS_RESP: begin
        if (s_axi_bready) begin
          r_next.bvalid = 1'b0;
          r_next.wstate = WS_COLLECT;
        end
      end
      default: r_next.wstate = WS_COLLECT;
    endcase
    // ready is withheld while a word waits or a response is pending
    r_next.awready = !r_next.aw_got && (r_next.wstate == WS_COLLECT);
    r_next.wready  = !r_next.w_got && (r_next.wstate == WS_COLLECT);

    // read channel
    case (r_reg.rstate)
      RS_IDLE: begin
        if (s_axi_arvalid && r_reg.arready) begin
          r_next.rdata  = reg_read(r_reg, s_axi_araddr);
          r_next.rresp  = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
          r_next.rvalid = 1'b1;
          r_next.rstate = RS_DATA;
        end
      end
      RS_DATA: begin
        if (s_axi_rready) begin
          r_next.rvalid = 1'b0;
          r_next.rstate = RS_IDLE;
        end
      end
      default: r_next.rstate = RS_IDLE;
    endcase
    r_next.arready = (r_next.rstate == RS_IDLE);

    // initialize overrides a config write in the same word
    if (do_init) begin
      r_next = mdio_defaults(r_next);
    end

    forward_run_in = term_hit(r_reg.in_func, lvl, IN_FWD);
    bwd = term_hit(r_reg.in_func, lvl, IN_BWD);
    // open contact on a fault-mapped terminal counts as fault
    ext_bad = term_hit(r_reg.in_func, ~lvl, IN_EXTF);
    // clear acts on the rising edge only
    clr_in          = term_hit(r_reg.in_func, lvl, IN_CLEAR);
    r_next.clr_prev = clr_in;
    if ((clr_in && !r_reg.clr_prev) || soft_clear) begin
      r_next.ol_alarm  = 1'b0;
      r_next.ext_alarm = 1'b0;
    end

    // overload persistence timer in 0.1 s ticks
    ol_any  = overload_cont_in || overload_limit_in || shaft_locked_in;
    ol_hard = overload_limit_in || shaft_locked_in;
    tick    = (r_reg.tick_cnt == 32'(TICK_CYCLES - 1));
    // timer restarts once no overload input (continuous, limit or shaft lock) is active
    if (!ol_any) begin
      r_next.tick_cnt = 32'h0;
      r_next.ol_ticks = 10'h0;
    end else if (tick) begin
      r_next.tick_cnt = 32'h0;
      r_next.ol_ticks = (r_reg.ol_ticks == OL_TIME_MAX) ? r_reg.ol_ticks : 10'(r_reg.ol_ticks + 10'h1);
    end else begin
      r_next.tick_cnt = 32'(r_reg.tick_cnt + 32'h1);
    end
    // hard overload capped at the fast limit
    limit = (ol_hard && r_reg.ol_time > OL_FAST_TICKS) ? OL_FAST_TICKS : r_reg.ol_time;
    // alarm once persistence reaches the limit; set beats clear
    // the updated count is used so the hard limit is not overrun by a cycle
    if (ol_any && r_next.ol_ticks >= limit) begin
      r_next.ol_alarm = 1'b1;
    end
    // external fault latches an alarm; set beats clear
    if (ext_bad) begin
      r_next.ext_alarm = 1'b1;
    end
    r_next.alarm = r_next.ol_alarm || r_next.ext_alarm;

    // both directions at once stops immediately
    r_next.run_fwd = forward_run_in && !bwd && !r_next.alarm;
    r_next.run_bwd = bwd && !forward_run_in && !r_next.alarm;
    r_next.stop    = (forward_run_in && bwd) || r_next.alarm;
    // both select inputs off gives data number zero
    r_next.data_num = {term_hit(r_reg.in_func, lvl, IN_SEL_H), term_hit(r_reg.in_func, lvl, IN_SEL_L)};
    // release only when position keeping is enabled
    hfree           = term_hit(r_reg.in_func, lvl, IN_HFREE);
    r_next.hold_rel = r_reg.hold_en && hfree;
    r_next.pos_keep = r_reg.hold_en && !hfree && !motor_running_in;

    // load above level raises the overload warning
    r_next.ol_warn = (load_factor_in > r_reg.warn_lvl);
    // warning is a live level, no latch
    r_next.warn    = r_next.ol_warn || drive_warning_in;
    r_next.moving  = motor_running_in;
    // speed within plus or minus band
    r_next.speed_ok = (mdio_absdiff(motor_speed_in, command_speed_in) <= {7'h0, r_reg.band});

    // fixed-width pulse per tick; a tick during a pulse is dropped
    if (rotation_tick_in && r_reg.tach_cnt == 32'h0) begin
      r_next.tach_cnt = 32'(PULSE_CYCLES);
    end else if (r_reg.tach_cnt != 32'h0) begin
      r_next.tach_cnt = 32'(r_reg.tach_cnt - 32'h1);
    end
    tach = (r_next.tach_cnt != 32'h0);

    st[0] = 1'b0;
    st[1] = !r_next.alarm;
    st[2] = tach;
    st[3] = !(r_next.ol_warn || r_next.ol_alarm);
    st[4] = r_next.moving;
    st[5] = r_next.speed_ok;
    st[6] = r_next.warn;
    // each terminal shows its selected status
    r_next.out_a = out_pick(r_reg.out_func[2:0], st);
    r_next.out_b = out_pick(r_reg.out_func[5:3], st);

    // unity increasing ratio hands over to the reduction ratio
    r_next.ratio_inc_sel = (r_reg.ratio_inc != RATIO_UNITY);
    r_next.disp_ratio    = r_next.ratio_inc_sel ? r_reg.ratio_inc : r_reg.ratio_red;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= mdio_defaults('0);
    end else begin
      r_reg <= r_next;
    end
  end

  assign s_axi_awready       = r_reg.awready;
  assign s_axi_wready        = r_reg.wready;
  assign s_axi_bvalid        = r_reg.bvalid;
  assign s_axi_bresp         = r_reg.bresp;
  assign s_axi_arready       = r_reg.arready;
  assign s_axi_rvalid        = r_reg.rvalid;
  assign s_axi_rdata         = r_reg.rdata;
  assign s_axi_rresp         = r_reg.rresp;
  assign output_terminal_a   = r_reg.out_a;
  assign output_terminal_b   = r_reg.out_b;
  assign run_forward         = r_reg.run_fwd;
  assign run_backward        = r_reg.run_bwd;
  assign stop_instant        = r_reg.stop;
  assign data_number         = r_reg.data_num;
  assign alarm_active        = r_reg.alarm;
  assign hold_release        = r_reg.hold_rel;
  assign position_keep       = r_reg.pos_keep;
  assign display_ratio       = r_reg.disp_ratio;
  assign ratio_from_increase = r_reg.ratio_inc_sel;

endmodule : mdio_top

/* File: tb/mdio_plc_model.sv */
module mdio_plc_model (
  input  wire logic       aclk,
  input  wire logic [2:0] term_cmd,
  output logic            input_terminal_a,
  output logic            input_terminal_b,
  output logic            input_terminal_c
);
  timeunit 1ns;
  timeprecision 1ns;
  // terminal levels held
  // levels only change after an edge, so the pin synchronizer sees a clean step
  always_ff @(posedge aclk) begin
    {input_terminal_c, input_terminal_b, input_terminal_a} <= term_cmd;
  end
endmodule : mdio_plc_model

/* File: tb/mdio_checker.sv */
module mdio_checker #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        run_forward,
  input wire logic        run_backward,
  input wire logic        stop_instant,
  input wire logic        alarm_active,
  input wire logic        hold_release,
  input wire logic        position_keep,
  input wire logic [15:0] display_ratio,
  input wire logic        ratio_from_increase,
  input wire logic        overload_limit_in,
  input wire logic        motor_running_in
);
  import mdio_pkg::*;
  // small margin covers the registering slack on the fast limit
  localparam int FAST_MAX = 50 * TICK_CYCLES + 20;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_lim_on; $rose(overload_limit_in); endsequence
  sequence s_alarm2; alarm_active [*2]; endsequence
  sequence s_run2; motor_running_in [*2]; endsequence
  property p_alarm_stop; s_alarm2 |-> stop_instant; endproperty
  property p_alarm_norun; s_alarm2 |-> !run_forward && !run_backward; endproperty
  property p_no_both; !(run_forward && run_backward); endproperty
  property p_run_stop; run_forward || run_backward |-> !stop_instant; endproperty
  property p_ratio; ratio_from_increase |-> display_ratio != RATIO_UNITY; endproperty
  property p_hold; hold_release |-> !position_keep; endproperty
  property p_keep; s_run2 |=> !position_keep; endproperty
  property p_fast; s_lim_on |-> ##[0:FAST_MAX] (alarm_active || !overload_limit_in); endproperty
  a_alarm_stop: assert property (p_alarm_stop) else $error("no stop during alarm");
  a_alarm_norun: assert property (p_alarm_norun) else $error("run during alarm");
  a_no_both: assert property (p_no_both) else $error("both directions on");
  a_run_stop: assert property (p_run_stop) else $error("run with stop");
  a_ratio: assert property (p_ratio) else $error("unity ratio flagged");
  a_hold: assert property (p_hold) else $error("keep while released");
  a_keep: assert property (p_keep) else $error("keep while running");
  a_fast: assert property (p_fast) else $error("fast overload alarm late");
endmodule : mdio_checker

/* File: tb/mdio_top_test.sv */
module mdio_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mdio_pkg::*;
  localparam int TK = 10;
  localparam int PC = 4;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, output_terminal_a, output_terminal_b;
  logic        input_terminal_a, input_terminal_b, input_terminal_c;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, load_factor_in = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, data_number;
  logic [15:0] motor_speed_in = 0, command_speed_in = 0, display_ratio;
  logic        overload_cont_in = 0, overload_limit_in = 0, shaft_locked_in = 0;
  logic        rotation_tick_in = 0, motor_running_in = 0, drive_warning_in = 0;
  logic        run_forward, run_backward, stop_instant, alarm_active;
  logic        hold_release, position_keep, ratio_from_increase;
  logic [2:0]  term_cmd = 0;
  int          error_cnt = 0, samples_checked = 0, n;
  always #5 aclk = ~aclk;
  mdio_plc_model plc (.aclk, .term_cmd, .input_terminal_a, .input_terminal_b, .input_terminal_c);
  mdio_top #(.TICK_CYCLES(TK), .PULSE_CYCLES(PC)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .input_terminal_a, .input_terminal_b, .input_terminal_c, .output_terminal_a,
    .output_terminal_b, .motor_speed_in, .command_speed_in, .load_factor_in, .overload_cont_in,
    .overload_limit_in, .shaft_locked_in, .rotation_tick_in, .motor_running_in, .drive_warning_in,
    .run_forward, .run_backward, .stop_instant, .data_number, .alarm_active, .hold_release,
    .position_keep, .display_ratio, .ratio_from_increase);
  task automatic results;
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chk
  task automatic w(input int c);
    repeat (c) @(posedge aclk);
  endtask : w
  // three cycles pin to output plus the model's own flop
  task automatic trm(input logic [2:0] c);
    term_cmd <= c;
    w(6);
  endtask : trm
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  logic [7:0]  ra[5] = '{REG_IN_FUNC, REG_OUT_FUNC, REG_OL_TIME, REG_WARN_LVL, REG_BAND};
  logic [31:0] re[5] = '{{IN_SEL_L, IN_BWD, IN_FWD}, {OUT_MAIN, OUT_TACH}, 32'h12C, 32'h78, 32'hC8};
  initial begin
    w(3);
    aresetn <= 1'b1;
    w(1);
    for (int i = 0; i < 5; i++) begin
      rdr(ra[i]);
      chk(rd, re[i]);
    end
    rdr(8'h40);
    chk(rd | 32'(resp), 32'(RESP_SLVERR));
    wr(8'h40, 32'hFFFF_FFFF);
    chk(resp, RESP_SLVERR);
    chk(output_terminal_b, 1);
    rotation_tick_in <= 1'b1;
    w(1);
    rotation_tick_in <= 1'b0;
    n = 0;
    repeat (12) begin
      w(1);
      n += output_terminal_a;
    end
    chk(n, PC);
    trm(3'b001);
    chk(run_forward, 1);
    trm(3'b010);
    chk(run_backward, 1);
    trm(3'b011);
    chk(stop_instant, 1);
    trm(3'b100);
    chk(data_number, 1);
    trm(3'b000);
    chk(data_number, 0);
    wr(REG_IN_FUNC, {IN_SEL_H, IN_SEL_L, IN_FWD});
    chk(resp, RESP_OKAY);
    trm(3'b110);
    chk(data_number, 3);
    wr(REG_IN_FUNC, {IN_FWD, IN_NONE, IN_FWD});
    trm(3'b110);
    chk(run_forward, 1);
    trm(3'b010);
    wr(REG_IN_FUNC, {IN_CLEAR, IN_EXTF, IN_HFREE});
    trm(3'b000);
    chk(alarm_active & stop_instant & !output_terminal_b, 1);
    trm(3'b010);
    trm(3'b110);
    trm(3'b010);
    chk(alarm_active, 0);
    wr(REG_CTRL, 32'h2);
    w(3);
    chk(position_keep, 1);
    trm(3'b011);
    chk(hold_release & !position_keep, 1);
    trm(3'b010);
    wr(REG_OUT_FUNC, {OUT_MOVE, OUT_OVLD});
    load_factor_in <= 8'd121;
    w(3);
    chk(output_terminal_a, 0);
    load_factor_in <= 8'd120;
    motor_running_in <= 1'b1;
    w(3);
    chk({output_terminal_b, output_terminal_a}, 2'b11);
    motor_running_in <= 1'b0;
    w(3);
    chk(output_terminal_b, 0);
    wr(REG_OUT_FUNC, {OUT_WARN, OUT_SPEED});
    motor_speed_in <= 16'd1000;
    command_speed_in <= 16'd1200;
    drive_warning_in <= 1'b1;
    w(3);
    chk({output_terminal_b, output_terminal_a}, 2'b11);
    command_speed_in <= 16'd1201;
    drive_warning_in <= 1'b0;
    w(3);
    chk({output_terminal_b, output_terminal_a}, 2'b00);
    command_speed_in <= 16'd1200;
    wr(REG_OUT_FUNC, {OUT_MAIN, OUT_NONE});
    w(2);
    chk({output_terminal_b, output_terminal_a}, 2'b10);
    for (int i = 0; i < 2; i++) begin
      overload_limit_in <= (i == 0);
      shaft_locked_in <= (i == 1);
      w(50 * TK - 20);
      chk(alarm_active, 0);
      w(30);
      chk(alarm_active & !output_terminal_b, 1);
      overload_limit_in <= 1'b0;
      shaft_locked_in <= 1'b0;
      trm(3'b110);
      trm(3'b010);
      chk(alarm_active, 0);
    end
    wr(REG_OL_TIME, 32'd2);
    overload_cont_in <= 1'b1;
    w(15);
    overload_cont_in <= 1'b0;
    w(2);
    overload_cont_in <= 1'b1;
    w(15);
    chk(alarm_active, 0);
    w(15);
    chk(alarm_active, 1);
    overload_cont_in <= 1'b0;
    wr(REG_CTRL, 32'h1);
    rdr(REG_OL_TIME);
    chk(rd, 32'h12C);
    wr(REG_RATIO_INC, 32'd150);
    w(2);
    chk({ratio_from_increase, display_ratio}, {1'b1, 16'd150});
    wr(REG_RATIO_RED, 32'd300);
    wr(REG_RATIO_INC, 32'd100);
    w(2);
    chk({ratio_from_increase, display_ratio}, {1'b0, 16'd300});
    results();
  end
  initial begin
    #100us;
    error_cnt++;
    results();
  end
endmodule : mdio_top_test
bind mdio_top mdio_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.aclk, .aresetn, .run_forward, .run_backward,
  .stop_instant, .alarm_active, .hold_release, .position_keep, .display_ratio, .ratio_from_increase,
  .overload_limit_in, .motor_running_in);
